// >>> verilog/ocf_pkg.sv
// Constants and types shared by the open-circuit flag register bank
package ocf_pkg;

  localparam int AXI_ADDR_W   = 12;
  localparam int AXI_DATA_W   = 32;
  localparam int AXI_STRB_W   = 4;
  localparam int WORD_IDX_W   = 10;
  localparam int NUM_CH       = 12;
  localparam int GROUP_W      = 3;

  localparam logic [WORD_IDX_W-1:0] IDX_FLAGS_ONE_TWO    = 10'h0a7;
  localparam logic [WORD_IDX_W-1:0] IDX_FLAGS_THREE_FOUR = 10'h0a8;
  localparam logic [WORD_IDX_W-1:0] IDX_EVT_STATUS       = 10'h0b0;
  localparam logic [WORD_IDX_W-1:0] IDX_EVT_CLEAR        = 10'h0b1;
  localparam logic [WORD_IDX_W-1:0] IDX_EVT_ENABLE       = 10'h0b2;

  localparam logic [AXI_ADDR_W-1:0] ADDR_FLAGS_ONE_TWO    = {IDX_FLAGS_ONE_TWO, 2'h0};
  localparam logic [AXI_ADDR_W-1:0] ADDR_FLAGS_THREE_FOUR = {IDX_FLAGS_THREE_FOUR, 2'h0};
  localparam logic [AXI_ADDR_W-1:0] ADDR_EVT_STATUS       = {IDX_EVT_STATUS, 2'h0};
  localparam logic [AXI_ADDR_W-1:0] ADDR_EVT_CLEAR        = {IDX_EVT_CLEAR, 2'h0};
  localparam logic [AXI_ADDR_W-1:0] ADDR_EVT_ENABLE       = {IDX_EVT_ENABLE, 2'h0};

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [7:0]        FLAGS_RESET = 8'h00;
  localparam logic [NUM_CH-1:0] EVT_RESET   = 12'h000;
  localparam logic              RSVD_VALUE  = 1'h0;

  // Layout of one open-fault flag register
  typedef struct packed {
    logic               rsvd_hi;
    logic [GROUP_W-1:0] group_hi;
    logic               rsvd_lo;
    logic [GROUP_W-1:0] group_lo;
  } ocf_flag_reg_s;

  // Detector indications, one per channel
  typedef struct packed {
    logic open_fault_group4_ch2;
    logic open_fault_group4_ch1;
    logic open_fault_group4_ch0;
    logic open_fault_group3_ch2;
    logic open_fault_group3_ch1;
    logic open_fault_group3_ch0;
    logic open_fault_group2_ch2;
    logic open_fault_group2_ch1;
    logic open_fault_group2_ch0;
    logic open_fault_group1_ch2;
    logic open_fault_group1_ch1;
    logic open_fault_group1_ch0;
  } ocf_det_s;

endpackage

// >>> verilog/ocf_sync.sv
// Two-flop synchroniser for detector levels
`timescale 1ns/1ps
module ocf_sync #(
  parameter int WIDTH = 12
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  always_comb begin
    next_meta = async_in;
    next_sync = meta;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= next_meta;
      sync_out <= next_sync;
    end
  end

endmodule // ocf_sync

// >>> verilog/ocf_sticky.sv
// Sticky event bits, set wins over clear
`timescale 1ns/1ps
module ocf_sticky #(
  parameter int WIDTH = 12
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic [WIDTH-1:0] clear_in,
  output logic      [WIDTH-1:0] flags_out
);

  logic [WIDTH-1:0] next_flags;

  always_comb begin
    next_flags = (flags_out & ~clear_in) | set_in;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags_out <= '0;
    end else begin
      flags_out <= next_flags;
    end
  end

endmodule // ocf_sticky

// >>> verilog/ocf_regs.sv
// Open-circuit flag register bank with AXI4-Lite slave and fault event interrupt
// Functional notes
// [R01] The first flag register sits at index A7h, resets to zero and its bits 3 and 7 always read zero.
// [R02] Bits 0 to 2 of the first flag register show the open faults of group one channels 0 to 2.
// [R03] Bits 4 to 6 of the first flag register show the open faults of group two channels 0 to 2.
// [R04] The second flag register sits at index A8h, resets to zero and its bits 3 and 7 always read zero.
// [R05] Bits 0 to 2 of the second flag register show the open faults of group three channels 0 to 2.
// [R06] Bits 4 to 6 of the second flag register show the open faults of group four channels 0 to 2.
// [R07] A flag reads one while its channel has an open fault and zero otherwise.
// [R08] Writes to the flag registers change nothing; flags follow only their channel detectors.
`timescale 1ns/1ps
module ocf_regs #(
  parameter int NUM_CH = 12
) (
  input  wire logic                                clk_in,
  input  wire logic                                rst_in,
  input  wire ocf_pkg::ocf_det_s                   open_fault_det_in,
  input  wire logic [ocf_pkg::AXI_ADDR_W-1:0]      s_axi_awaddr_in,
  input  wire logic                                s_axi_awvalid_in,
  output logic                                     s_axi_awready_out,
  input  wire logic [ocf_pkg::AXI_DATA_W-1:0]      s_axi_wdata_in,
  input  wire logic [ocf_pkg::AXI_STRB_W-1:0]      s_axi_wstrb_in,
  input  wire logic                                s_axi_wvalid_in,
  output logic                                     s_axi_wready_out,
  output logic [1:0]                               s_axi_bresp_out,
  output logic                                     s_axi_bvalid_out,
  input  wire logic                                s_axi_bready_in,
  input  wire logic [ocf_pkg::AXI_ADDR_W-1:0]      s_axi_araddr_in,
  input  wire logic                                s_axi_arvalid_in,
  output logic                                     s_axi_arready_out,
  output logic [ocf_pkg::AXI_DATA_W-1:0]           s_axi_rdata_out,
  output logic [1:0]                               s_axi_rresp_out,
  output logic                                     s_axi_rvalid_out,
  input  wire logic                                s_axi_rready_in,
  output logic                                     irq_out
);

  logic [NUM_CH-1:0]                  det_sync;
  ocf_pkg::ocf_det_s                  det_s;
  logic [NUM_CH-1:0]                  det_prev;
  logic [NUM_CH-1:0]                  evt_rise;
  logic [NUM_CH-1:0]                  evt_status;
  logic [NUM_CH-1:0]                  evt_clear;
  logic [NUM_CH-1:0]                  evt_enable;
  ocf_pkg::ocf_flag_reg_s             flags_one_two;
  ocf_pkg::ocf_flag_reg_s             flags_three_four;
  logic                               aw_held;
  logic                               w_held;
  logic [ocf_pkg::WORD_IDX_W-1:0]     aw_idx;
  logic [NUM_CH-1:0]                  w_data;
  logic [ocf_pkg::AXI_STRB_W-1:0]     w_strb;
  logic [NUM_CH-1:0]                  w_mask;
  logic                               write_fire;

  logic                               next_awready;
  logic                               next_wready;
  logic [1:0]                         next_bresp;
  logic                               next_bvalid;
  logic                               next_arready;
  logic [ocf_pkg::AXI_DATA_W-1:0]     next_rdata;
  logic [1:0]                         next_rresp;
  logic                               next_rvalid;
  logic                               next_aw_held;
  logic                               next_w_held;
  logic [ocf_pkg::WORD_IDX_W-1:0]     next_aw_idx;
  logic [NUM_CH-1:0]                  next_w_data;
  logic [ocf_pkg::AXI_STRB_W-1:0]     next_w_strb;
  logic [NUM_CH-1:0]                  next_evt_enable;
  logic [NUM_CH-1:0]                  next_det_prev;
  ocf_pkg::ocf_flag_reg_s             next_flags_one_two;
  ocf_pkg::ocf_flag_reg_s             next_flags_three_four;
  logic                               next_irq;

  // Detector levels come from the analog side
  ocf_sync #(
    .WIDTH (NUM_CH)
  ) u_det_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in (open_fault_det_in),
    .sync_out (det_sync)
  );

  assign det_s    = ocf_pkg::ocf_det_s'(det_sync);
  assign evt_rise = det_sync & ~det_prev;

  ocf_sticky #(
    .WIDTH (NUM_CH)
  ) u_evt_status (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .set_in    (evt_rise),
    .clear_in  (evt_clear),
    .flags_out (evt_status)
  );

  function automatic ocf_pkg::ocf_flag_reg_s pack_flags(input logic [ocf_pkg::GROUP_W-1:0] lo,
                                                        input logic [ocf_pkg::GROUP_W-1:0] hi);
    ocf_pkg::ocf_flag_reg_s r;
    r.rsvd_hi  = ocf_pkg::RSVD_VALUE;
    r.group_hi = hi;
    r.rsvd_lo  = ocf_pkg::RSVD_VALUE;
    r.group_lo = lo;
    return r;
  endfunction

  function automatic logic is_mapped(input logic [ocf_pkg::WORD_IDX_W-1:0] idx);
    return (idx == ocf_pkg::IDX_FLAGS_ONE_TWO) || (idx == ocf_pkg::IDX_FLAGS_THREE_FOUR) ||
           (idx == ocf_pkg::IDX_EVT_STATUS) || (idx == ocf_pkg::IDX_EVT_CLEAR) ||
           (idx == ocf_pkg::IDX_EVT_ENABLE);
  endfunction

  function automatic logic [ocf_pkg::AXI_DATA_W-1:0] read_word(input logic [ocf_pkg::WORD_IDX_W-1:0] idx);
    logic [ocf_pkg::AXI_DATA_W-1:0] d;
    d = '0;
    if (idx == ocf_pkg::IDX_FLAGS_ONE_TWO) begin
      d = ocf_pkg::AXI_DATA_W'(flags_one_two); // R01
    end else if (idx == ocf_pkg::IDX_FLAGS_THREE_FOUR) begin
      d = ocf_pkg::AXI_DATA_W'(flags_three_four); // R04
    end else if (idx == ocf_pkg::IDX_EVT_STATUS) begin
      d = ocf_pkg::AXI_DATA_W'(evt_status);
    end else if (idx == ocf_pkg::IDX_EVT_ENABLE) begin
      d = ocf_pkg::AXI_DATA_W'(evt_enable);
    end
    return d;
  endfunction

  assign w_mask     = {{4{w_strb[1]}}, {8{w_strb[0]}}};
  assign write_fire = aw_held && w_held && !s_axi_bvalid_out;

  always_comb begin
    next_aw_held    = aw_held;
    next_w_held     = w_held;
    next_aw_idx     = aw_idx;
    next_w_data     = w_data;
    next_w_strb     = w_strb;
    next_bvalid     = s_axi_bvalid_out;
    next_bresp      = s_axi_bresp_out;
    next_rvalid     = s_axi_rvalid_out;
    next_rdata      = s_axi_rdata_out;
    next_rresp      = s_axi_rresp_out;
    next_evt_enable = evt_enable;
    evt_clear       = '0;
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      next_aw_held = 1'b1;
      next_aw_idx  = s_axi_awaddr_in[ocf_pkg::AXI_ADDR_W-1:2];
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata_in[NUM_CH-1:0];
      next_w_strb = s_axi_wstrb_in;
    end
    if (write_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = is_mapped(aw_idx) ? ocf_pkg::RESP_OKAY : ocf_pkg::RESP_SLVERR;
      // Flag registers take no write data
      if (aw_idx == ocf_pkg::IDX_EVT_CLEAR) begin // R08
        evt_clear = w_data & w_mask;
      end else if (aw_idx == ocf_pkg::IDX_EVT_ENABLE) begin
        next_evt_enable = (evt_enable & ~w_mask) | (w_data & w_mask);
      end
    end
    if (s_axi_bvalid_out && s_axi_bready_in) begin
      next_bvalid = 1'b0;
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      next_rvalid = 1'b1;
      next_rdata  = read_word(s_axi_araddr_in[ocf_pkg::AXI_ADDR_W-1:2]);
      next_rresp  = is_mapped(s_axi_araddr_in[ocf_pkg::AXI_ADDR_W-1:2]) ? ocf_pkg::RESP_OKAY
                                                                         : ocf_pkg::RESP_SLVERR;
    end
    if (s_axi_rvalid_out && s_axi_rready_in) begin
      next_rvalid = 1'b0;
    end
    next_arready = !next_rvalid;
  end

  always_comb begin
    next_flags_one_two    = pack_flags({det_s.open_fault_group1_ch2, det_s.open_fault_group1_ch1,
                                        det_s.open_fault_group1_ch0},
                                       {det_s.open_fault_group2_ch2, det_s.open_fault_group2_ch1,
                                        det_s.open_fault_group2_ch0}); // R02 R03 R07 R08
    next_flags_three_four = pack_flags({det_s.open_fault_group3_ch2, det_s.open_fault_group3_ch1,
                                        det_s.open_fault_group3_ch0},
                                       {det_s.open_fault_group4_ch2, det_s.open_fault_group4_ch1,
                                        det_s.open_fault_group4_ch0}); // R05 R06 R07 R08
    next_det_prev         = det_sync;
    next_irq              = |(evt_status & evt_enable);
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= ocf_pkg::RESP_OKAY;
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= '0;
      s_axi_rresp_out   <= ocf_pkg::RESP_OKAY;
      aw_held           <= 1'b0;
      w_held            <= 1'b0;
      aw_idx            <= '0;
      w_data            <= '0;
      w_strb            <= '0;
      evt_enable        <= ocf_pkg::EVT_RESET;
    end else begin
      s_axi_awready_out <= next_awready;
      s_axi_wready_out  <= next_wready;
      s_axi_bvalid_out  <= next_bvalid;
      s_axi_bresp_out   <= next_bresp;
      s_axi_arready_out <= next_arready;
      s_axi_rvalid_out  <= next_rvalid;
      s_axi_rdata_out   <= next_rdata;
      s_axi_rresp_out   <= next_rresp;
      aw_held           <= next_aw_held;
      w_held            <= next_w_held;
      aw_idx            <= next_aw_idx;
      w_data            <= next_w_data;
      w_strb            <= next_w_strb;
      evt_enable        <= next_evt_enable;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags_one_two    <= ocf_pkg::FLAGS_RESET; // R01
      flags_three_four <= ocf_pkg::FLAGS_RESET; // R04
      det_prev         <= '0;
      irq_out          <= 1'b0;
    end else begin
      flags_one_two    <= next_flags_one_two;
      flags_three_four <= next_flags_three_four;
      det_prev         <= next_det_prev;
      irq_out          <= next_irq;
    end
  end

  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_rd_one_two;
    s_axi_arvalid_in && s_axi_arready_out && (s_axi_araddr_in[ocf_pkg::AXI_ADDR_W-1:2] == ocf_pkg::IDX_FLAGS_ONE_TWO);
  endsequence

  sequence s_rd_three_four;
    s_axi_arvalid_in && s_axi_arready_out &&
      (s_axi_araddr_in[ocf_pkg::AXI_ADDR_W-1:2] == ocf_pkg::IDX_FLAGS_THREE_FOUR);
  endsequence

  sequence s_wr_flags;
    write_fire && ((aw_idx == ocf_pkg::IDX_FLAGS_ONE_TWO) || (aw_idx == ocf_pkg::IDX_FLAGS_THREE_FOUR));
  endsequence

  a_read_one_two: assert property (s_rd_one_two |=> s_axi_rvalid_out && s_axi_rresp_out == ocf_pkg::RESP_OKAY &&
                                   s_axi_rdata_out == ocf_pkg::AXI_DATA_W'($past(flags_one_two))) // R01
    else $error("first flag register read returned wrong data");

  a_read_three_four: assert property (s_rd_three_four |=> s_axi_rvalid_out && s_axi_rresp_out == ocf_pkg::RESP_OKAY &&
                                      s_axi_rdata_out == ocf_pkg::AXI_DATA_W'($past(flags_three_four))) // R04
    else $error("second flag register read returned wrong data");

  a_rsvd_one_two: assert property (!flags_one_two.rsvd_hi && !flags_one_two.rsvd_lo) // R01
    else $error("reserved bit set in first flag register");

  a_rsvd_three_four: assert property (!flags_three_four.rsvd_hi && !flags_three_four.rsvd_lo) // R04
    else $error("reserved bit set in second flag register");

  a_group_one_map: assert property (flags_one_two.group_lo == $past(det_sync[2:0])) // R02
    else $error("group one flags do not follow detectors");

  a_group_two_map: assert property (flags_one_two.group_hi == $past(det_sync[5:3])) // R03
    else $error("group two flags do not follow detectors");

  a_group_three_map: assert property (flags_three_four.group_lo == $past(det_sync[8:6])) // R05
    else $error("group three flags do not follow detectors");

  a_group_four_map: assert property (flags_three_four.group_hi == $past(det_sync[11:9])) // R06
    else $error("group four flags do not follow detectors");

  a_fault_seen: assert property ($rose(det_sync[0]) ##1 det_sync[0] |-> flags_one_two.group_lo[0]) // R07
    else $error("held fault not reported as one");

  a_ro_write: assert property (s_wr_flags |=> s_axi_bvalid_out && s_axi_bresp_out == ocf_pkg::RESP_OKAY &&
                               $stable(evt_enable) && evt_clear == '0) // R08
    else $error("write to flag register had an effect");

  a_read_latency: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out ##0 !s_axi_arready_out)
    else $error("read answer not one cycle after address");

  a_write_resp: assert property (aw_held && w_held && !s_axi_bvalid_out |=> s_axi_bvalid_out && !aw_held && !w_held)
    else $error("write response missing");

  a_event_sticky: assert property ((|evt_rise) |=> ((evt_status & $past(evt_rise)) == $past(evt_rise)))
    else $error("fault event not latched");

  a_irq_level: assert property (irq_out == |($past(evt_status) & $past(evt_enable)))
    else $error("interrupt does not follow enabled status");

endmodule // ocf_regs

// >>> tb/ocf_regs_tb.sv
// Self-checking testbench for the open-circuit flag register bank
`timescale 1ns/1ps
module ocf_regs_tb;
  logic              clk_in;
  logic              rst_in;
  ocf_pkg::ocf_det_s det;
  logic [11:0]       awaddr;
  logic              awvalid;
  logic [31:0]       wdata;
  logic [3:0]        wstrb;
  logic              wvalid;
  logic              bready;
  logic [11:0]       araddr;
  logic              arvalid;
  logic              rready;
  logic              awready;
  logic              wready;
  logic [1:0]        bresp;
  logic              bvalid;
  logic              arready;
  logic [31:0]       rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  logic              irq;
  int                fail_count;
  int                checks_done;

  ocf_regs #(.NUM_CH(12)) u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .open_fault_det_in(det),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .irq_out(irq)
  );

  always #20 clk_in = ~clk_in;

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic hang(input string what);
    fail_count++;
    $display("wrong value at %0t: %s timed out", $time, what);
    finish_test();
  endtask

  // AXI4-Lite write, address and data offered together
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] er, input string what);
    int n;
    bit aw_done;
    bit w_done;
    bit got;
    n = 0;
    aw_done = 0;
    w_done = 0;
    got = 0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (aw_done && w_done && bvalid === 1'b1) begin
        got = 1;
        check({30'h0, bresp}, {30'h0, er}, what);
      end
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end while (!got && n < 100);
    if (!got) hang(what);
  endtask

  // AXI4-Lite read, compares data and response
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er, input string what);
    int n;
    bit ar_done;
    bit got;
    n = 0;
    ar_done = 0;
    got = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (ar_done && rvalid === 1'b1) begin
        got = 1;
        check(rdata, ed, what);
        check({30'h0, rresp}, {30'h0, er}, what);
      end
      if (!ar_done && arready === 1'b1) begin
        ar_done = 1;
        arvalid <= 1'b0;
      end
    end while (!got && n < 100);
    if (!got) hang(what);
  endtask

  // Expected flag word for a detector pattern; sel 0 is groups one/two, 1 is groups three/four
  function automatic logic [31:0] exp_flags(input logic [11:0] d, input int sel);
    logic [31:0] r;
    r = 32'h0;
    for (int c = 0; c < 12; c++) begin
      if (d[c] && (c / 6) == sel) r[((c / 3) % 2) * 4 + c % 3] = 1'b1;
    end
    return r;
  endfunction

  task automatic settle();
    repeat (5) @(posedge clk_in);
  endtask

  initial begin
    clk_in = 1'b0;
    rst_in = 1'b1;
    det = '0;
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wstrb = '0;
    wvalid = 1'b0;
    // Response readies stay high for the whole run
    bready = 1'b1;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b1;
    fail_count = 0;
    checks_done = 0;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rd_chk(ocf_pkg::ADDR_FLAGS_ONE_TWO, 32'h0, ocf_pkg::RESP_OKAY, "reset one_two");
    rd_chk(ocf_pkg::ADDR_FLAGS_THREE_FOUR, 32'h0, ocf_pkg::RESP_OKAY, "reset three_four");
    rd_chk(ocf_pkg::ADDR_EVT_ENABLE, 32'h0, ocf_pkg::RESP_OKAY, "reset enable");
    check({31'h0, irq}, 32'h0, "irq after reset");
    // One channel at a time, both registers read
    for (int n = 0; n < 12; n++) begin
      det <= ocf_pkg::ocf_det_s'(12'h001 << n);
      settle();
      rd_chk(ocf_pkg::ADDR_FLAGS_ONE_TWO, exp_flags(12'h001 << n, 0), ocf_pkg::RESP_OKAY, "walk one_two");
      rd_chk(ocf_pkg::ADDR_FLAGS_THREE_FOUR, exp_flags(12'h001 << n, 1), ocf_pkg::RESP_OKAY, "walk three_four");
    end
    // All faults present: reserved bits stay zero, writes change nothing
    det <= ocf_pkg::ocf_det_s'(12'hfff);
    settle();
    axi_write(ocf_pkg::ADDR_FLAGS_ONE_TWO, 32'h0, 4'hf, ocf_pkg::RESP_OKAY, "write one_two");
    axi_write(ocf_pkg::ADDR_FLAGS_THREE_FOUR, 32'h0, 4'hf, ocf_pkg::RESP_OKAY, "write three_four");
    rd_chk(ocf_pkg::ADDR_FLAGS_ONE_TWO, 32'h77, ocf_pkg::RESP_OKAY, "all one_two");
    rd_chk(ocf_pkg::ADDR_FLAGS_THREE_FOUR, 32'h77, ocf_pkg::RESP_OKAY, "all three_four");
    det <= ocf_pkg::ocf_det_s'(12'h000);
    settle();
    axi_write(ocf_pkg::ADDR_FLAGS_ONE_TWO, 32'hffffffff, 4'hf, ocf_pkg::RESP_OKAY, "set one_two");
    rd_chk(ocf_pkg::ADDR_FLAGS_ONE_TWO, 32'h0, ocf_pkg::RESP_OKAY, "gone one_two");
    rd_chk(ocf_pkg::ADDR_FLAGS_THREE_FOUR, 32'h0, ocf_pkg::RESP_OKAY, "gone three_four");
    // Unmapped place, one write and one read
    axi_write(12'h100, 32'h1, 4'hf, ocf_pkg::RESP_SLVERR, "unmapped write");
    rd_chk(12'h100, 32'h0, ocf_pkg::RESP_SLVERR, "unmapped read");
    // Event status, enable, clear and interrupt
    rd_chk(ocf_pkg::ADDR_EVT_STATUS, 32'hfff, ocf_pkg::RESP_OKAY, "sticky status");
    axi_write(ocf_pkg::ADDR_EVT_STATUS, 32'h0, 4'hf, ocf_pkg::RESP_OKAY, "write status");
    axi_write(ocf_pkg::ADDR_EVT_CLEAR, 32'hfff, 4'h3, ocf_pkg::RESP_OKAY, "clear all");
    rd_chk(ocf_pkg::ADDR_EVT_STATUS, 32'h0, ocf_pkg::RESP_OKAY, "status cleared");
    rd_chk(ocf_pkg::ADDR_EVT_CLEAR, 32'h0, ocf_pkg::RESP_OKAY, "clear reads zero");
    axi_write(ocf_pkg::ADDR_EVT_ENABLE, 32'h801, 4'h3, ocf_pkg::RESP_OKAY, "enable");
    rd_chk(ocf_pkg::ADDR_EVT_ENABLE, 32'h801, ocf_pkg::RESP_OKAY, "enable readback");
    det <= ocf_pkg::ocf_det_s'(12'h002);
    settle();
    check({31'h0, irq}, 32'h0, "masked event");
    rd_chk(ocf_pkg::ADDR_EVT_STATUS, 32'h002, ocf_pkg::RESP_OKAY, "masked status");
    det <= ocf_pkg::ocf_det_s'(12'h003);
    settle();
    check({31'h0, irq}, 32'h1, "enabled event");
    axi_write(ocf_pkg::ADDR_EVT_ENABLE, 32'h0, 4'h3, ocf_pkg::RESP_OKAY, "mask");
    repeat (2) @(posedge clk_in);
    check({31'h0, irq}, 32'h0, "irq masked");
    axi_write(ocf_pkg::ADDR_EVT_ENABLE, 32'h001, 4'h3, ocf_pkg::RESP_OKAY, "unmask");
    repeat (2) @(posedge clk_in);
    check({31'h0, irq}, 32'h1, "irq unmasked");
    axi_write(ocf_pkg::ADDR_EVT_CLEAR, 32'h001, 4'h1, ocf_pkg::RESP_OKAY, "clear one");
    repeat (2) @(posedge clk_in);
    check({31'h0, irq}, 32'h0, "irq cleared");
    rd_chk(ocf_pkg::ADDR_EVT_STATUS, 32'h002, ocf_pkg::RESP_OKAY, "status after clear");
    rd_chk(ocf_pkg::ADDR_FLAGS_ONE_TWO, 32'h3, ocf_pkg::RESP_OKAY, "flags live");
    finish_test();
  end
endmodule // ocf_regs_tb
